// [inc/gli_consts.svh]
`ifndef GLI_CONSTS_SVH
`define GLI_CONSTS_SVH
`define GLI_NUM_PINS 3
`define GLI_PIN_SPEED 0
`define GLI_PIN_LINK 1
`define GLI_PIN_DUPLEX 2
`define GLI_BLINK_MS 80
`define GLI_CLK_KHZ 125000
`define GLI_BLINK_CYCLES (`GLI_BLINK_MS * `GLI_CLK_KHZ)
`define GLI_SYNC_STAGES 2
`define GLI_RESET_LED_N 1'b1
`endif

// [inc/gli_pkg.sv]
package gli_pkg;
    typedef enum logic [1:0] {
        GLI_MODE_INPUT,
        GLI_MODE_PUSH_PULL,
        GLI_MODE_OPEN_DRAIN
    } gli_mode_t;
    typedef struct packed {
        logic linkUp;
        logic speed100;
        logic fullDuplex;
        logic autoNeg;
        logic activity;
    } gli_link_t;
endpackage

// [rtl/gli_blink_timer.sv]
`timescale 1ns/1ps
`include "gli_consts.svh"
// activity blink: off for one period, then on for at least one period
module gli_blink_timer #(
    parameter int unsigned PERIOD = `GLI_BLINK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstSyncB,
    // status in
    input wire logic linkUp,
    input wire logic activity,
    // led out, low is on
    output logic ledN
);
    localparam int CW = $clog2(PERIOD + 1);
    typedef enum logic [1:0] {GLI_B_IDLE, GLI_B_OFF, GLI_B_ON} gli_blink_t;
    initial begin
        if (PERIOD < 1) $error("PERIOD must be at least 1");
    end
    gli_blink_t state_ff, nxt_state;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic pend_ff, nxt_pend;
    logic led_ff, nxt_led;
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_pend = pend_ff | activity;
        nxt_led = led_ff;
        if (!linkUp) begin
            nxt_state = GLI_B_IDLE;
            nxt_cnt = '0;
            nxt_pend = 1'b0;
            nxt_led = 1'b1;
        end else begin
            case (state_ff)
                GLI_B_IDLE: begin
                    nxt_led = 1'b0;
                    if (pend_ff) begin
                        nxt_state = GLI_B_OFF;
                        nxt_cnt = '0;
                        nxt_pend = activity;
                        nxt_led = 1'b1;
                    end
                end
                GLI_B_OFF: begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == LAST) begin
                        nxt_state = GLI_B_ON;
                        nxt_cnt = '0;
                        nxt_led = 1'b0;
                    end
                end
                GLI_B_ON: begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == LAST) begin
                        nxt_state = GLI_B_IDLE;
                        nxt_cnt = '0;
                    end
                end
                default: begin
                    nxt_state = GLI_B_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            state_ff <= GLI_B_IDLE;
            cnt_ff <= '0;
            pend_ff <= 1'b0;
            led_ff <= `GLI_RESET_LED_N;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            pend_ff <= nxt_pend;
            led_ff <= nxt_led;
        end
    end
    assign ledN = led_ff;
endmodule

// [rtl/gpio_led_indicator.sv]
`timescale 1ns/1ps
`include "gli_consts.svh"
// How it works
// - three pins: push-pull, open-drain or input
// - led select makes a pin open-drain only
// - speed led low at 100Mb with link up and autoneg off, else high
// - link led low while link valid
// - activity pulses link led high 80ms
// - then low at least 80ms before repeat
// - duplex led low in full duplex with link up
// - strap high enables auto crossover, low disables
module gpio_led_indicator #(
    parameter int unsigned NUM_PINS = `GLI_NUM_PINS,
    parameter int unsigned BLINK_CYCLES = `GLI_BLINK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // pin configuration per pin
    input wire gli_pkg::gli_mode_t [NUM_PINS-1:0] pinMode,
    input wire logic [NUM_PINS-1:0] pinLedSel,
    input wire logic [NUM_PINS-1:0] pinOutData,
    output logic [NUM_PINS-1:0] pinInData,
    // link status from phy
    input wire gli_pkg::gli_link_t linkStat,
    // pads, output enable low means driving
    input wire logic [NUM_PINS-1:0] padIn,
    output logic [NUM_PINS-1:0] padOut,
    output logic [NUM_PINS-1:0] padOeN,
    // crossover strap
    input wire logic crossover_auto_strap,
    output logic crossoverAutoEn
);
    // elaboration checks: the led map and the strap counter rely on these
    initial begin
        if (NUM_PINS != `GLI_NUM_PINS) begin
            $error("NUM_PINS must be 3");
        end
        if (BLINK_CYCLES < 1) begin
            $error("BLINK_CYCLES must be at least 1");
        end
        if (`GLI_SYNC_STAGES < 1 || `GLI_SYNC_STAGES > 2) begin
            $error("strap wait must be 1 or 2 cycles");
        end
    end

    // internal reset leaves on a clock edge, two flops after rst_b rises
    logic rstS1_ff;
    logic rstSyncB_ff;
    logic nxt_rstS1;
    logic nxt_rstSyncB;

    always_comb begin
        nxt_rstS1 = 1'b1;
        nxt_rstSyncB = rstS1_ff;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstS1_ff <= 1'b0;
            rstSyncB_ff <= 1'b0;
        end else begin
            rstS1_ff <= nxt_rstS1;
            rstSyncB_ff <= nxt_rstSyncB;
        end
    end

    // pad and strap synchronisers, only the second stage is read
    logic [NUM_PINS-1:0] padS1_ff;
    logic [NUM_PINS-1:0] padS2_ff;
    logic [NUM_PINS-1:0] nxt_padS1;
    logic [NUM_PINS-1:0] nxt_padS2;
    logic strapS1_ff;
    logic strapS2_ff;
    logic nxt_strapS1;
    logic nxt_strapS2;

    always_comb begin
        nxt_padS1 = padIn;
        nxt_padS2 = padS1_ff;
        nxt_strapS1 = crossover_auto_strap;
        nxt_strapS2 = strapS1_ff;
    end

    always_ff @(posedge clk or negedge rstSyncB_ff) begin
        if (!rstSyncB_ff) begin
            padS1_ff <= '0;
            padS2_ff <= '0;
            strapS1_ff <= 1'b1;
            strapS2_ff <= 1'b1;
        end else begin
            padS1_ff <= nxt_padS1;
            padS2_ff <= nxt_padS2;
            strapS1_ff <= nxt_strapS1;
            strapS2_ff <= nxt_strapS2;
        end
    end

    // strap taken once, after the synchroniser holds the real pin level;
    // earlier edges would only see the reset value of the sync flops
    localparam logic [1:0] STRAP_TAKE = 2'(`GLI_SYNC_STAGES);
    logic [1:0] strapCnt_ff;
    logic [1:0] nxt_strapCnt;
    logic strap_ff;
    logic nxt_strap;

    always_comb begin
        nxt_strapCnt = strapCnt_ff;
        nxt_strap = strap_ff;
        if (strapCnt_ff < STRAP_TAKE) begin
            nxt_strapCnt = strapCnt_ff + 2'h1;
        end else if (strapCnt_ff == STRAP_TAKE) begin
            nxt_strapCnt = STRAP_TAKE + 2'h1;
            nxt_strap = strapS2_ff;
        end
    end

    always_ff @(posedge clk or negedge rstSyncB_ff) begin
        if (!rstSyncB_ff) begin
            strapCnt_ff <= 2'h0;
            strap_ff <= 1'b1;
        end else begin
            strapCnt_ff <= nxt_strapCnt;
            strap_ff <= nxt_strap;
        end
    end

    // led sources, low is on
    logic speed_led_n;
    logic link_activity_led_n;
    logic duplex_led_n;
    logic [NUM_PINS-1:0] ledVal;

    // link and activity led with its blink timing
    gli_blink_timer #(
        .PERIOD(BLINK_CYCLES)
    ) u_blink (
        .clk(clk),
        .rstSyncB(rstSyncB_ff),
        .linkUp(linkStat.linkUp),
        .activity(linkStat.activity),
        .ledN(link_activity_led_n)
    );

    always_comb begin
        // speed low only when linked at 100 and not negotiating
        speed_led_n = ~(linkStat.linkUp & linkStat.speed100 & ~linkStat.autoNeg);
        duplex_led_n = ~(linkStat.linkUp & linkStat.fullDuplex);
        // pins outside the led map stay released
        ledVal = '1;
        ledVal[`GLI_PIN_SPEED] = speed_led_n;
        ledVal[`GLI_PIN_LINK] = link_activity_led_n;
        ledVal[`GLI_PIN_DUPLEX] = duplex_led_n;
    end

    // per pin drive: led select overrides the configured mode
    logic [NUM_PINS-1:0] nxt_out;
    logic [NUM_PINS-1:0] nxt_oeN;
    logic [NUM_PINS-1:0] out_ff;
    logic [NUM_PINS-1:0] oeN_ff;
    genvar gi;

    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            always_comb begin
                nxt_out[gi] = 1'b0;
                nxt_oeN[gi] = 1'b1;
                if (pinLedSel[gi]) begin
                    // led pins only sink, the pull-up gives the off level
                    nxt_oeN[gi] = ledVal[gi];
                end else begin
                    case (pinMode[gi])
                        gli_pkg::GLI_MODE_PUSH_PULL: begin
                            nxt_out[gi] = pinOutData[gi];
                            nxt_oeN[gi] = 1'b0;
                        end
                        gli_pkg::GLI_MODE_OPEN_DRAIN: begin
                            nxt_oeN[gi] = pinOutData[gi];
                        end
                        default: begin
                            nxt_oeN[gi] = 1'b1;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // registered pad drive, reset leaves every pad released
    always_ff @(posedge clk or negedge rstSyncB_ff) begin
        if (!rstSyncB_ff) begin
            out_ff <= '0;
            oeN_ff <= '1;
        end else begin
            out_ff <= nxt_out;
            oeN_ff <= nxt_oeN;
        end
    end

    // input path: synchronised pad level, one more register to the port
    logic [NUM_PINS-1:0] nxt_in;
    logic [NUM_PINS-1:0] in_ff;

    always_comb begin
        nxt_in = padS2_ff;
    end

    always_ff @(posedge clk or negedge rstSyncB_ff) begin
        if (!rstSyncB_ff) begin
            in_ff <= '0;
        end else begin
            in_ff <= nxt_in;
        end
    end

    // every output straight from a flop
    assign padOut = out_ff;
    assign padOeN = oeN_ff;
    assign pinInData = in_ff;
    assign crossoverAutoEn = strap_ff;
endmodule

// [tb/gli_props.sv]
`timescale 1ns/1ps
module gli_props #(parameter int unsigned NUM_PINS = 3, parameter int unsigned BLINK_CYCLES = 8) (
    input wire logic clk,
    input wire logic rst_b,
    input wire gli_pkg::gli_mode_t [NUM_PINS-1:0] pinMode,
    input wire logic [NUM_PINS-1:0] pinLedSel,
    input wire gli_pkg::gli_link_t linkStat,
    input wire logic [NUM_PINS-1:0] padOut,
    input wire logic [NUM_PINS-1:0] padOeN,
    input wire logic crossoverAutoEn
);
    logic [2:0] rc_ff;
    int hi_ff, lo_ff;
    wire rdy = rc_ff == 3'h7;
    wire lnk = linkStat.linkUp && pinLedSel[1];
    // high and low run lengths of the link led while the link is up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rc_ff <= 3'h0;
            hi_ff <= 0;
            lo_ff <= BLINK_CYCLES;
        end else begin
            rc_ff <= rdy ? rc_ff : rc_ff + 3'h1;
            hi_ff <= lnk && padOeN[1] ? hi_ff + 1 : 0;
            lo_ff <= !lnk ? BLINK_CYCLES : !padOeN[1] ? lo_ff + 1 : hi_ff > 4 ? 0 : lo_ff;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence ledHeld(int i);
        (rdy && pinLedSel[i] && $stable(linkStat)) [*3];
    endsequence
    chk_led_drain: assert property (rdy |-> (pinLedSel & $past(pinLedSel) & padOut) == '0)
        else $error("led pin driven high");
    chk_gpio_input: assert property ((rdy && !pinLedSel[0] && pinMode[0] == gli_pkg::GLI_MODE_INPUT) [*2]
        |-> padOeN[0]) else $error("input pin driven");
    chk_speed_led: assert property (ledHeld(0) |-> padOeN[0] == !(linkStat.linkUp && linkStat.speed100
        && !linkStat.autoNeg)) else $error("speed led wrong");
    chk_duplex_led: assert property (ledHeld(2) |-> padOeN[2] == !(linkStat.linkUp && linkStat.fullDuplex))
        else $error("duplex led wrong");
    chk_link_off: assert property ((rdy && pinLedSel[1] && !linkStat.linkUp) [*3] |-> padOeN[1])
        else $error("link led on without link");
    chk_blink_len: assert property ($fell(padOeN[1]) && hi_ff > 4 |-> hi_ff >= BLINK_CYCLES
        && hi_ff <= BLINK_CYCLES + 1) else $error("blink length wrong");
    chk_blink_gap: assert property ($rose(padOeN[1]) |-> lo_ff >= BLINK_CYCLES)
        else $error("blink gap too short");
    chk_strap_hold: assert property (rdy && $past(rdy) |-> $stable(crossoverAutoEn))
        else $error("strap value changed");
endmodule
bind gpio_led_indicator gli_props #(.NUM_PINS(NUM_PINS), .BLINK_CYCLES(BLINK_CYCLES)) props (.clk(clk),
    .rst_b(rst_b), .pinMode(pinMode), .pinLedSel(pinLedSel), .linkStat(linkStat), .padOut(padOut),
    .padOeN(padOeN), .crossoverAutoEn(crossoverAutoEn));

// [tb/gli_board.sv]
`timescale 1ns/1ps
module gli_board (
    input wire logic [2:0] padOut,
    input wire logic [2:0] padOeN,
    input wire logic drv,
    output logic [2:0] padLvl
);
    // released pads sit at the pull-up, pad 0 is driven by the board
    assign padLvl = ~padOeN & padOut | padOeN & {2'h3, drv};
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned BLINK = 8;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic strap, autoEn;
    logic [2:0] sel, dout, din, pOut, pOeN, pLvl;
    gli_pkg::gli_mode_t [2:0] mode;
    gli_pkg::gli_link_t link;
    int err_count = 0;
    int total_checks = 0;
    int n;
    always #4 clk = ~clk;
    gpio_led_indicator #(.NUM_PINS(3), .BLINK_CYCLES(BLINK)) dut (.clk(clk), .rst_b(rst_b), .pinMode(mode),
        .pinLedSel(sel), .pinOutData(dout), .pinInData(din), .linkStat(link), .padIn(pLvl), .padOut(pOut),
        .padOeN(pOeN), .crossover_auto_strap(strap), .crossoverAutoEn(autoEn));
    gli_board board (.padOut(pOut), .padOeN(pOeN), .drv(dout[0]), .padLvl(pLvl));
    task results;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task reset(input logic s);
        @(posedge clk);
        rst_b <= 1'b0;
        strap <= s;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(negedge clk);
    endtask
    // length of the next run of the link led at level lvl
    task runOf(input logic lvl);
        int w;
        n = 0;
        for (w = 0; w < 30 && pOeN[1] !== lvl; w++) @(negedge clk);
        while (pOeN[1] === lvl && n < 99) begin
            n++;
            @(negedge clk);
        end
        if (w == 30 || n == 99) begin
            chk(1'b0, 1'b1, "led stuck");
            results();
        end
    endtask
    task tStrap;
        reset(1'b0);
        chk(autoEn, 1'b0, "strap low");
        reset(1'b1);
        chk(autoEn, 1'b1, "strap high");
    endtask
    task tGpio;
        @(posedge clk);
        mode[1] <= gli_pkg::GLI_MODE_PUSH_PULL;
        mode[2] <= gli_pkg::GLI_MODE_OPEN_DRAIN;
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            dout <= {3{v[0]}};
            repeat (5) @(negedge clk);
            chk(pOeN[0] & (din[0] ~^ v[0]), 1'b1, "input pin");
            chk(pOeN[1] | (pLvl[1] ^ v[0]), 1'b0, "push-pull");
            chk(pOeN[2] & pLvl[2], v[0], "open-drain");
        end
    endtask
    task tLeds;
        @(posedge clk);
        sel <= 3'h7;
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            link <= {c[0], c[1], c[2], c[3], 1'b0};
            repeat (4) @(negedge clk);
            chk(pOeN[0], !(c[0] && c[1] && !c[3]), "speed led");
            chk(pOeN[1], !c[0], "link led");
            chk(pOeN[2], !(c[0] && c[2]), "duplex led");
            chk(|pOut, 1'b0, "led driven high");
        end
    endtask
    task tBlink;
        @(posedge clk);
        link <= {1'b1, 4'h1};
        runOf(1'b1);
        chk(n == BLINK, 1'b1, "blink length");
        runOf(1'b0);
        chk(n >= BLINK, 1'b1, "gap length");
        runOf(1'b1);
        chk(n == BLINK, 1'b1, "repeat blink");
        @(posedge clk);
        link <= 5'h0;
        repeat (3) @(negedge clk);
        chk(pOeN[1], 1'b1, "link lost");
    endtask
    initial begin
        for (int i = 0; i < 3; i++) mode[i] = gli_pkg::GLI_MODE_INPUT;
        sel = 3'h0;
        dout = 3'h0;
        link = 5'h0;
        strap = 1'b1;
        tStrap();
        tGpio();
        tLeds();
        tBlink();
        results();
    end
endmodule
